/* tws_pkg.sv */
package tws_pkg;

  // ----------------------------------------
  // Bus timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SCL_MAX_KHZ = 400;
  localparam int unsigned T_LOW_MIN_NS = 1300;
  localparam int unsigned T_HIGH_MIN_NS = 600;
  localparam int unsigned T_STA_HOLD_NS = 600;
  localparam int unsigned T_STO_SETUP_NS = 600;
  localparam int unsigned T_BUF_NS = 1300;
  localparam int unsigned T_DATA_HOLD_NS = 100;
  // One quarter of an SCL period: half the least low time, rounded up
  localparam int unsigned QTR_CYC = (T_LOW_MIN_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Framing
  // ----------------------------------------
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h47;
  localparam logic RW_READ = 1'b1;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_SLOT = 4'h9;
  localparam int unsigned REG_AW = 8;
  localparam int unsigned REG_SPACE = 256;
  localparam int unsigned FIFO_DEPTH_DEF = 2;

  // Byte position inside a host transfer
  localparam logic [1:0] HB_DEV = 2'h0;
  localparam logic [1:0] HB_REG = 2'h1;
  localparam logic [1:0] HB_DATA = 2'h2;
  localparam logic [1:0] HB_RDATA = 2'h3;

  typedef enum logic [2:0] {D_IDLE, D_DEVADR, D_REGADR, D_WDATA, D_RDATA, D_IGNORE} tws_dev_state_type;
  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_RSTART, H_STOP, H_GAP} tws_host_state_type;

endpackage

/* tws_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface tws_if;
  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Open-drain wires with pull-ups
  assign scl = !(host_scl_oe && !host_scl_out);
  assign sda = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));

  modport host (output host_scl_out, host_scl_oe, host_sda_out, host_sda_oe, input scl, sda);
  modport dev (output dev_sda_out, dev_sda_oe, input scl, sda);
endinterface

`default_nettype wire

/* tws_dev_end.sv */
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Two-wire slave, reads and writes, 400 kbit/s.
// - Write: address, direction, register, data, acks.
// - Answer slave address, default 47H.
// - Data changes only while clock low.
// - Start is data falling, clock high.
// - Stop is data rising, ends transfer.
// - First byte after start is address+direction.
// - Slave acks each written byte, ninth clock; nacks a data byte when the write buffer is full.
// - Master acks bytes the slave sends.
// - Single write: register, one data, stop.
// - Further bytes stored, pointer increments each, until the write buffer is full.
// - Read starts alike, direction bit one.
// - Pointer is last access plus one.
// - Current read: one byte, master nacks, stops.
// - Random read: set pointer, repeated start.
// - Master ack: increment, send next byte.
// - Pointer wraps from FFH to 00H.
// - Unused addresses read without error.
// - Master waits 0.6 us after start.
// - Master holds clock high 0.6 us before stop.
// - Master leaves 1.3 us between stop, start.
// - Master holds data 100 ns after fall.
module tws_dev_end #(
  parameter logic [6:0] SLAVE_ADDR = tws_pkg::SLAVE_ADDR_DEF, // Bus address
  parameter int unsigned FIFO_DEPTH = tws_pkg::FIFO_DEPTH_DEF // Write buffer depth
) (
  tws_if.dev bus, // Two-wire bus
  input wire logic sys_clk_in, // System clock
  input wire logic sys_rst_in, // Synchronous reset
  output logic cfg_valid_out, // Written byte waiting
  output logic [tws_pkg::REG_AW-1:0] cfg_addr_out, // Its register address
  output logic [7:0] cfg_data_out, // Its data
  input wire logic cfg_ready_in // Consumer takes byte
);
  import tws_pkg::*;

  localparam int unsigned CW = $clog2(FIFO_DEPTH + 1);

  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic scl_f_reg;
  logic sda_f_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  tws_dev_state_type st_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] rx_sh_reg;
  logic [7:0] tx_sh_reg;
  logic rw_reg;
  logic mack_reg;
  logic [7:0] ptr_reg;
  logic sda_oe_reg;
  logic [7:0] regs_mem [REG_SPACE];
  logic [15:0] slot_reg [FIFO_DEPTH];
  logic [CW-1:0] fcnt_reg;
  logic [CW-1:0] fcnt_next;
  logic vld_reg;
  logic full;
  logic push;
  logic pop;
  logic active;

  // ----------------------------------------
  // Pin sampling
  // ----------------------------------------

  // Three-stage synchronisers, level taken when stages two and three agree
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], bus.scl};
      sda_sync_reg <= {sda_sync_reg[1:0], bus.sda};
      if (scl_sync_reg[1] == scl_sync_reg[2]) begin
        scl_f_reg <= scl_sync_reg[2];
      end
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin
        sda_f_reg <= sda_sync_reg[2];
      end
      scl_d_reg <= scl_f_reg;
      sda_d_reg <= sda_f_reg;
    end
  end

  // Clock edges and frame markers
  assign scl_rise = scl_f_reg && !scl_d_reg;
  assign scl_fall = !scl_f_reg && scl_d_reg;
  assign start_det = sda_d_reg && !sda_f_reg && scl_f_reg && scl_d_reg;
  assign stop_det = !sda_d_reg && sda_f_reg && scl_f_reg && scl_d_reg;
  assign active = (st_reg != D_IDLE) && (st_reg != D_IGNORE);

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------

  // Byte framing, acknowledge, pointer and read data
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      st_reg <= D_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      tx_sh_reg <= 8'h00;
      rw_reg <= 1'b0;
      mack_reg <= 1'b0;
      ptr_reg <= 8'h00;
      sda_oe_reg <= 1'b0;
    end else if (start_det) begin
      st_reg <= D_DEVADR;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (stop_det) begin
      st_reg <= D_IDLE;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (scl_rise && active) begin
      if (bit_cnt_reg < ACK_SLOT) begin
        rx_sh_reg <= {rx_sh_reg[6:0], sda_f_reg};
      end else begin
        mack_reg <= !sda_f_reg;
      end
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end else if (scl_fall && active) begin
      // All drive changes happen just after the clock falls
      if (bit_cnt_reg == ACK_SLOT) begin
        sda_oe_reg <= 1'b0;
        case (st_reg)
          D_DEVADR: begin
            if (rx_sh_reg[7:1] == SLAVE_ADDR) begin
              sda_oe_reg <= 1'b1;
              rw_reg <= rx_sh_reg[0];
            end else begin
              st_reg <= D_IGNORE;
            end
          end
          D_REGADR: begin
            sda_oe_reg <= 1'b1;
            ptr_reg <= rx_sh_reg;
          end
          D_WDATA: begin
            if (!full) begin
              sda_oe_reg <= 1'b1;
              ptr_reg <= ptr_reg + 8'h01;
            end else begin
              st_reg <= D_IGNORE;
            end
          end
          default: begin
            sda_oe_reg <= 1'b0;
          end
        endcase
      end else if (bit_cnt_reg == LAST_SLOT) begin
        bit_cnt_reg <= 4'h0;
        sda_oe_reg <= 1'b0;
        case (st_reg)
          D_DEVADR: begin
            if (rw_reg == RW_READ) begin
              st_reg <= D_RDATA;
              tx_sh_reg <= regs_mem[ptr_reg];
              sda_oe_reg <= !regs_mem[ptr_reg][7];
              ptr_reg <= ptr_reg + 8'h01;
            end else begin
              st_reg <= D_REGADR;
            end
          end
          D_REGADR: begin
            st_reg <= D_WDATA;
          end
          D_RDATA: begin
            if (mack_reg) begin
              tx_sh_reg <= regs_mem[ptr_reg];
              sda_oe_reg <= !regs_mem[ptr_reg][7];
              ptr_reg <= ptr_reg + 8'h01;
            end else begin
              st_reg <= D_IGNORE;
            end
          end
          default: begin
            st_reg <= st_reg;
          end
        endcase
      end else if (st_reg == D_RDATA && bit_cnt_reg != 4'h0) begin
        tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
        sda_oe_reg <= !tx_sh_reg[6];
      end
    end
  end

  // Pin drives low only; released otherwise
  assign bus.dev_sda_out = 1'b0;
  assign bus.dev_sda_oe = sda_oe_reg;

  // ----------------------------------------
  // Register space
  // ----------------------------------------

  // Full 256-byte space so any address reads back cleanly
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < REG_SPACE; i++) begin
        regs_mem[i] <= 8'h00;
      end
    end else if (push) begin
      regs_mem[ptr_reg] <= rx_sh_reg;
    end
  end

  // ----------------------------------------
  // Write buffer
  // ----------------------------------------

  // Accepted bytes; a full buffer makes the slave refuse the byte
  assign full = (fcnt_reg == CW'(FIFO_DEPTH));
  assign push = scl_fall && (bit_cnt_reg == ACK_SLOT) && (st_reg == D_WDATA) && !full && !start_det && !stop_det;
  assign pop = vld_reg && cfg_ready_in;
  assign fcnt_next = fcnt_reg + CW'(push) - CW'(pop);

  // Shift-register queue, head slot feeds the outputs
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      fcnt_reg <= '0;
      vld_reg <= 1'b0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        slot_reg[i] <= 16'h0000;
      end
    end else begin
      fcnt_reg <= fcnt_next;
      vld_reg <= (fcnt_next != '0);
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        if (pop && i < FIFO_DEPTH - 1) begin
          slot_reg[i] <= slot_reg[i + 1];
        end
        if (push && i == int'(fcnt_reg - CW'(pop))) begin
          slot_reg[i] <= {ptr_reg, rx_sh_reg};
        end
      end
    end
  end

  assign cfg_valid_out = vld_reg;
  assign cfg_addr_out = slot_reg[0][15:8];
  assign cfg_data_out = slot_reg[0][7:0];

endmodule

`default_nettype wire

/* tws_host_end.sv */
`timescale 1ns/1ns
`default_nettype none

module tws_host_end #(
  parameter logic [6:0] SLAVE_ADDR = tws_pkg::SLAVE_ADDR_DEF // Target address
) (
  tws_if.host bus, // Two-wire bus
  input wire logic sys_clk_in, // System clock
  input wire logic sys_rst_in, // Synchronous reset
  input wire logic cmd_valid_in, // Command request
  output logic cmd_ready_out, // Idle, takes command
  input wire logic cmd_read_in, // 1 random read, 0 write
  input wire logic [7:0] cmd_reg_in, // Register address
  input wire logic [7:0] cmd_data_in, // Write data
  output logic rsp_valid_out, // Command done pulse
  output logic [7:0] rsp_data_out, // Read data
  output logic rsp_nack_out // Slave refused a byte
);
  import tws_pkg::*;

  localparam int unsigned QW = $clog2(QTR_CYC);

  tws_host_state_type st_reg;
  logic [QW-1:0] qc_reg;
  logic [1:0] ph_reg;
  logic [3:0] bit_cnt_reg;
  logic [1:0] byte_idx_reg;
  logic [7:0] sh_reg;
  logic [7:0] reg_reg;
  logic [7:0] data_reg;
  logic [7:0] rdata_reg;
  logic rw_reg;
  logic nack_reg;
  logic scl_low_reg;
  logic sda_low_reg;
  logic [2:0] sda_sync_reg;
  logic sda_f_reg;
  logic tick;
  logic is_tx;

  // ----------------------------------------
  // Pin sampling and clock divider
  // ----------------------------------------

  // Data line synchroniser and quarter-period counter
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sda_sync_reg <= 3'h7;
      sda_f_reg <= 1'b1;
      qc_reg <= '0;
    end else begin
      sda_sync_reg <= {sda_sync_reg[1:0], bus.sda};
      if (sda_sync_reg[1] == sda_sync_reg[2]) begin
        sda_f_reg <= sda_sync_reg[2];
      end
      qc_reg <= tick ? '0 : qc_reg + QW'(1);
    end
  end

  assign tick = (qc_reg == QW'(QTR_CYC - 1));
  assign is_tx = !(rw_reg && byte_idx_reg == HB_RDATA);

  // ----------------------------------------
  // Transfer sequencer
  // ----------------------------------------

  // Quarter phases: 0 clock falls, 1 data set, 2 clock rises, 3 sample
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      st_reg <= H_IDLE;
      ph_reg <= 2'h0;
      bit_cnt_reg <= 4'h0;
      byte_idx_reg <= HB_DEV;
      sh_reg <= 8'h00;
      reg_reg <= 8'h00;
      data_reg <= 8'h00;
      rdata_reg <= 8'h00;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      cmd_ready_out <= 1'b1;
      rsp_valid_out <= 1'b0;
      rsp_data_out <= 8'h00;
      rsp_nack_out <= 1'b0;
    end else begin
      rsp_valid_out <= 1'b0;
      if (st_reg == H_IDLE) begin
        if (cmd_valid_in && cmd_ready_out) begin
          cmd_ready_out <= 1'b0;
          rw_reg <= cmd_read_in;
          reg_reg <= cmd_reg_in;
          data_reg <= cmd_data_in;
          byte_idx_reg <= HB_DEV;
          nack_reg <= 1'b0;
          ph_reg <= 2'h3;
          st_reg <= H_START;
        end
      end else if (tick) begin
        ph_reg <= ph_reg + 2'h1;
        case (st_reg)
          H_START: begin
            if (ph_reg == 2'h3) begin
              sda_low_reg <= 1'b1;
            end else if (ph_reg == 2'h1) begin
              scl_low_reg <= 1'b1;
              sh_reg <= {SLAVE_ADDR, byte_idx_reg != HB_DEV};
              bit_cnt_reg <= 4'h0;
              ph_reg <= 2'h1;
              st_reg <= H_BIT;
            end
          end
          H_BIT: begin
            if (ph_reg == 2'h0) begin
              scl_low_reg <= 1'b1;
              if (bit_cnt_reg == LAST_SLOT) begin
                bit_cnt_reg <= 4'h0;
                byte_idx_reg <= byte_idx_reg + 2'h1;
                if (byte_idx_reg == HB_RDATA) begin
                  rdata_reg <= sh_reg;
                end
                if (nack_reg || byte_idx_reg == HB_RDATA || (byte_idx_reg == HB_DATA && !rw_reg)) begin
                  st_reg <= H_STOP;
                end else if (byte_idx_reg == HB_REG && rw_reg) begin
                  st_reg <= H_RSTART;
                end else begin
                  sh_reg <= (byte_idx_reg == HB_DEV) ? reg_reg : data_reg;
                end
              end
            end else if (ph_reg == 2'h1) begin
              // Data moves a quarter after the fall, never while high
              sda_low_reg <= (bit_cnt_reg < ACK_SLOT) && is_tx && !sh_reg[7];
            end else if (ph_reg == 2'h2) begin
              scl_low_reg <= 1'b0;
            end else begin
              if (bit_cnt_reg < ACK_SLOT) begin
                sh_reg <= {sh_reg[6:0], sda_f_reg};
              end else if (is_tx) begin
                nack_reg <= sda_f_reg;
              end
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
          H_RSTART: begin
            if (ph_reg == 2'h1) begin
              sda_low_reg <= 1'b0;
            end else if (ph_reg == 2'h2) begin
              scl_low_reg <= 1'b0;
              st_reg <= H_START;
            end
          end
          H_STOP: begin
            if (ph_reg == 2'h1) begin
              sda_low_reg <= 1'b1;
            end else if (ph_reg == 2'h2) begin
              scl_low_reg <= 1'b0;
            end else if (ph_reg == 2'h0) begin
              sda_low_reg <= 1'b0;
              st_reg <= H_GAP;
            end
          end
          H_GAP: begin
            if (ph_reg == 2'h2) begin
              st_reg <= H_IDLE;
              cmd_ready_out <= 1'b1;
              rsp_valid_out <= 1'b1;
              rsp_data_out <= rdata_reg;
              rsp_nack_out <= nack_reg;
            end
          end
          default: begin
            st_reg <= H_IDLE;
          end
        endcase
      end
    end
  end

  // Both lines driven open-drain
  assign bus.host_scl_out = 1'b0;
  assign bus.host_scl_oe = scl_low_reg;
  assign bus.host_sda_out = 1'b0;
  assign bus.host_sda_oe = sda_low_reg;

endmodule

`default_nettype wire

/* tws_bus_sva.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Bus watcher for the host-to-device link
// ----------------------------------------
module tws_bus_sva (
  input wire logic sys_clk_in, // System clock
  input wire logic sys_rst_in, // Synchronous reset
  input wire logic host_scl_oe, // Host pulls clock low
  input wire logic host_sda_oe, // Host pulls data low
  input wire logic dev_sda_oe, // Device pulls data low
  input wire logic scl, // Resolved clock line
  input wire logic sda // Resolved data line
);
  logic scl_q_reg, sda_q_reg, first_reg, rw_reg, stopped_reg;
  logic [3:0] bit_reg;
  logic [7:0] lo_reg, hi_reg, per_reg, free_reg;
  wire logic rise = scl && !scl_q_reg;
  wire logic start_ev = scl && scl_q_reg && sda_q_reg && !sda;
  wire logic stop_ev = scl && scl_q_reg && !sda_q_reg && sda;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  function automatic logic [7:0] sat(input logic [7:0] v);
    return (v == 8'hff) ? v : v + 8'h01;
  endfunction

  // Line history, phase counters and bit position
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      bit_reg <= 4'h0;
      first_reg <= 1'b0;
      rw_reg <= 1'b0;
      stopped_reg <= 1'b1;
      lo_reg <= 8'h00;
      hi_reg <= 8'h00;
      per_reg <= 8'hff;
      free_reg <= 8'hff;
    end else begin
      scl_q_reg <= scl;
      sda_q_reg <= sda;
      lo_reg <= scl ? 8'h00 : sat(lo_reg);
      hi_reg <= scl ? sat(hi_reg) : 8'h00;
      per_reg <= rise ? 8'h00 : sat(per_reg);
      free_reg <= stop_ev ? 8'h00 : sat(free_reg);
      if (stop_ev) begin
        stopped_reg <= 1'b1;
      end else if (start_ev) begin
        stopped_reg <= 1'b0;
      end
      if (start_ev) begin
        bit_reg <= 4'h0;
        first_reg <= 1'b1;
      end else if (rise) begin
        bit_reg <= (bit_reg == 4'h8) ? 4'h0 : bit_reg + 4'h1;
        if (bit_reg == 4'h8) begin
          first_reg <= 1'b0;
        end
        if (bit_reg == 4'h7 && first_reg) begin
          rw_reg <= sda;
        end
      end
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_rate; rise |-> per_reg >= 8'h32; endproperty
  property p_start_hold; $rose(host_sda_oe) && scl |-> (!host_scl_oe) [*8] ##1 (!host_scl_oe) [*4]; endproperty
  property p_stop_setup; $fell(host_sda_oe) && scl |-> hi_reg >= 8'h0c; endproperty
  property p_bus_free; $rose(host_sda_oe) && scl && stopped_reg |-> free_reg >= 8'h1a; endproperty
  property p_host_hold; $changed(host_sda_oe) && !scl |-> lo_reg >= 8'h02; endproperty
  property p_dev_edge; $changed(dev_sda_oe) |-> !scl && lo_reg >= 8'h02; endproperty
  property p_dev_ack; rise && bit_reg == 4'h8 && !(rw_reg && !first_reg) |-> dev_sda_oe; endproperty
  property p_read_release; rise && bit_reg == 4'h8 && rw_reg && !first_reg |-> !dev_sda_oe; endproperty
  property p_write_quiet; rise && bit_reg < 4'h8 && (first_reg || !rw_reg) |-> !dev_sda_oe; endproperty

  a_rate: assert property (p_rate) else $error("clock period too short");
  a_start_hold: assert property (p_start_hold) else $error("start hold too short");
  a_stop_setup: assert property (p_stop_setup) else $error("stop setup too short");
  a_bus_free: assert property (p_bus_free) else $error("bus free time too short");
  a_host_hold: assert property (p_host_hold) else $error("host data hold too short");
  a_dev_edge: assert property (p_dev_edge) else $error("device data moved with clock high");
  a_dev_ack: assert property (p_dev_ack) else $error("device missed an acknowledge");
  a_read_release: assert property (p_read_release) else $error("device drove master ack slot");
  a_write_quiet: assert property (p_write_quiet) else $error("device drove a host bit");

  // Main scenarios reached
  c_read_ack: cover property (rise && bit_reg == 4'h8 && rw_reg && !first_reg);
  c_stop: cover property (stop_ev);
  c_restart: cover property (start_ev && !stopped_reg);
endmodule

`default_nettype wire

/* two_wire_config_slave_port_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module two_wire_config_slave_port_tb;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid, cmd_read, ready1, ready2;
  logic [7:0] cmd_reg, cmd_data;
  wire logic cmd_ready, rsp_valid, rsp_nack, cv1, cv2;
  wire logic [7:0] rsp_data, ca1, cd1, ca2, cd2;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [15:0] q1[$];
  logic [15:0] q2[$];

  tws_if bus1();
  tws_if bus2();
  tws_host_end i_tws_host_end (.bus(bus1), .sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .cmd_valid_in(cmd_valid),
    .cmd_ready_out(cmd_ready), .cmd_read_in(cmd_read), .cmd_reg_in(cmd_reg), .cmd_data_in(cmd_data),
    .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data), .rsp_nack_out(rsp_nack));
  tws_dev_end i_tws_dev_end (.bus(bus1), .sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .cfg_valid_out(cv1),
    .cfg_addr_out(ca1), .cfg_data_out(cd1), .cfg_ready_in(ready1));
  tws_dev_end i_tws_dev_end_2 (.bus(bus2), .sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .cfg_valid_out(cv2),
    .cfg_addr_out(ca2), .cfg_data_out(cd2), .cfg_ready_in(ready2));
  tws_bus_sva i_tws_bus_sva (.sys_clk_in(sys_clk), .sys_rst_in(sys_rst), .host_scl_oe(bus1.host_scl_oe),
    .host_sda_oe(bus1.host_sda_oe), .dev_sda_oe(bus1.dev_sda_oe), .scl(bus1.scl), .sda(bus1.sda));

  // Clock
  always #25 sys_clk = ~sys_clk;

  // Collect stored words, cut a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cv1 && ready1) q1.push_back({ca1, cd1});
    if (cv2 && ready2) q2.push_back({ca2, cd2});
    if (cyc == 40000) begin
      num_errors++;
      $display("ERROR %0t: timeout", $time);
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic q(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // One bit with the link clock at 400 ns, data moved only while low
  // Low for 5 cycles so the slave's synchronised drive lands before the rise
  task automatic bit_io(input logic b, output logic r);
    q(2);
    bus2.host_sda_oe = !b;
    q(3);
    bus2.host_scl_oe = 1'b0;
    q(3);
    r = bus2.sda;
    bus2.host_scl_oe = 1'b1;
  endtask

  // Eight bits MSB first, then the ninth slot
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] r, output logic ak);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(a, ak);
  endtask

  task automatic start2();
    q(2);
    bus2.host_sda_oe = 1'b0;
    q(4);
    bus2.host_scl_oe = 1'b0;
    q(12);
    bus2.host_sda_oe = 1'b1;
    q(12);
    bus2.host_scl_oe = 1'b1;
  endtask

  task automatic stop2();
    q(2);
    bus2.host_sda_oe = 1'b1;
    q(2);
    bus2.host_scl_oe = 1'b0;
    q(12);
    bus2.host_sda_oe = 1'b0;
    q(26);
  endtask

  task automatic send(input logic [7:0] d, input logic nak);
    logic [7:0] r;
    logic ak;
    byte_io(d, 1'b1, r, ak);
    chk({15'h0000, ak}, {15'h0000, nak});
  endtask

  task automatic recv(input logic [7:0] e, input logic mnak);
    logic [7:0] r;
    logic ak;
    byte_io(8'hff, mnak, r, ak);
    chk({8'h00, r}, {8'h00, e});
  endtask

  // Host end command, wait for its response pulse
  task automatic cmd(input logic rd, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    int n;
    cmd_read = rd;
    cmd_reg = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(negedge sys_clk);
      n++;
    end
    chk({rsp_valid, rsp_nack, 6'h00, rd ? rsp_data : e}, {2'b10, 6'h00, e});
    chk({15'h0000, cmd_ready}, 16'h0001);
    @(negedge sys_clk);
  endtask

  // Main sequence
  initial begin
    bus2.host_scl_out = 1'b0;
    bus2.host_sda_out = 1'b0;
    bus2.host_scl_oe = 1'b0;
    bus2.host_sda_oe = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_reg = 8'h00;
    cmd_data = 8'h00;
    ready1 = 1'b1;
    ready2 = 1'b0;
    q(4);
    sys_rst = 1'b0;
    cmd(1'b0, 8'h10, 8'h5a, 8'h5a);
    chk(q1.pop_front(), 16'h105a);
    cmd(1'b1, 8'h10, 8'h00, 8'h5a);
    cmd(1'b0, 8'hff, 8'ha5, 8'ha5);
    chk(q1.pop_front(), 16'hffa5);
    cmd(1'b1, 8'hff, 8'h00, 8'ha5);
    cmd(1'b1, 8'h05, 8'h00, 8'h00);
    start2();
    send(8'h8e, 1'b0);
    send(8'hff, 1'b0);
    send(8'h11, 1'b0);
    send(8'h22, 1'b0);
    send(8'h33, 1'b1);
    stop2();
    chk(16'(q2.size()), 16'h0000);
    ready2 = 1'b1;
    q(4);
    chk(q2.pop_front(), 16'hff11);
    chk(q2.pop_front(), 16'h0022);
    start2();
    send(8'h8e, 1'b0);
    send(8'hfe, 1'b0);
    start2();
    send(8'h8f, 1'b0);
    recv(8'h00, 1'b0);
    recv(8'h11, 1'b1);
    stop2();
    start2();
    send(8'h8f, 1'b0);
    recv(8'h22, 1'b1);
    stop2();
    start2();
    send(8'h8c, 1'b1);
    send(8'h01, 1'b1);
    stop2();
    chk(16'(q2.size()), 16'h0000);
    end_of_test();
  end
endmodule

`default_nettype wire
